// file: hdl/iorp_defs.svh
`ifndef IORP_DEFS_SVH
`define IORP_DEFS_SVH
// ==========================================================
// register byte offsets
`define IORP_OFF_CTL0 12'h000
`define IORP_OFF_CTL1 12'h004
`define IORP_OFF_CNT0_LO 12'h008
`define IORP_OFF_CNT0_HI 12'h00c
`define IORP_OFF_CNT1_LO 12'h010
`define IORP_OFF_CNT1_HI 12'h014
`define IORP_OFF_FILTER 12'h018
// ==========================================================
// control word fields
`define IORP_EV_LSB 0
`define IORP_UM_LSB 8
`define IORP_EN_BIT 22
`define IORP_CLR_BIT 23
// ==========================================================
// event codes
`define IORP_EV_DRS_INS 8'h02
`define IORP_EV_NCB_INS 8'h03
`define IORP_EV_NCS_INS 8'h04
`define IORP_EV_DRS_FULL 8'h05
`define IORP_EV_NCB_FULL 8'h06
`define IORP_EV_NCS_FULL 8'h07
`define IORP_EV_DRS_OCC 8'h08
`define IORP_EV_NCB_OCC 8'h09
`define IORP_EV_NCS_OCC 8'h0a
`define IORP_EV_SW_OCC 8'h0c
`define IORP_EV_SW_NCB 8'h0d
`define IORP_EV_SW_NCS 8'h0e
`define IORP_EV_INBOUND 8'h11
`define IORP_EV_PEER_TXN 8'h13
`define IORP_EV_PEER_INS 8'h14
`define IORP_EV_PEER_OCC 8'h15
`define IORP_EV_RING0_STALL 8'h1a
`define IORP_EV_RING1_STALL 8'h1b
`define IORP_EV_RING01_STALL 8'h1c
`define IORP_EV_DATA_STALL 8'h1d
`define IORP_CTL_RESET 32'h0000_0000
`endif

// file: hdl/iorp_pkg.sv
`default_nettype none
package iorp_pkg;
  // ========================================================
  // per-cycle condition bundle from the port
  typedef struct packed {
    logic peer_req;          // peer request from inbound source
    logic [7:0] peer_occ;    // bypass plus stall queue entries
    logic [3:0] peer_kind;   // read, write, message, completion
    logic [3:0] peer_where;  // rem, rem+tgt, loc, loc+tgt
    logic in_req;            // inbound transaction this cycle
    logic [3:0] in_kind;     // write, prefetch, atomic, other
    logic in_retry;          // write retry
    logic [3:0] in_queue;    // source queue of the request
    logic [2:0] q_ins;       // drs, ncb, ncs insert
    logic [2:0] q_full;      // drs, ncb, ncs full
    logic [7:0] drs_occ;
    logic [7:0] ncb_occ;
    logic [7:0] ncs_occ;
    logic ring0_stall;       // no credit on first request ring
    logic ring1_stall;       // no credit on second request ring
    logic data_stall;        // no data ring credit
    logic [1:0] sw_ins;      // ncb, ncs switch request
    logic [7:0] sw_occ;      // outstanding switch requests
  } iorp_cond_type;
  typedef struct packed {
    logic en;
    logic [7:0] umask;
    logic [7:0] code;
  } iorp_sel_type;
endpackage
`default_nettype wire

// file: hdl/iorp_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "iorp_defs.svh"
module iorp_counter #(
  parameter int WIDTH = 48
) (
  input wire logic mclk,
  input wire logic rst,
  input wire iorp_pkg::iorp_sel_type sel,
  input wire iorp_pkg::iorp_cond_type cond,
  input wire logic [3:0] filter_q,
  input wire logic clr,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  output logic [WIDTH-1:0] count
);
  // ========================================================
  // event decode
  logic [8:0] inc;        // amount added this cycle
  logic [3:0] um_lo;
  logic [3:0] um_hi;
  logic [WIDTH-1:0] count_ff;
  assign um_lo = sel.umask[3:0];
  assign um_hi = sel.umask[7:4];
  assign count = count_ff;

  // at most one per cycle, two for the both-rings stall; occupancy adds the whole count
  always_comb begin
    inc = 9'h000;
    case (sel.code)
      `IORP_EV_PEER_INS: inc = {8'h00, cond.peer_req};
      `IORP_EV_PEER_OCC: inc = {1'b0, cond.peer_occ};
      // kind and locality masks must both hit
      `IORP_EV_PEER_TXN: inc = {8'h00, |(um_lo & cond.peer_kind) &
        |(um_hi & cond.peer_where)};
      // request types are or-reduced; source filter optional
      `IORP_EV_INBOUND: begin
        inc = {8'h00, cond.in_req &
          ((sel.umask[1] & (cond.in_kind[0] | cond.in_retry)) |
          |(sel.umask[5:3] & cond.in_kind[3:1])) &
          (!sel.umask[6] || cond.in_queue == filter_q)};
      end
      `IORP_EV_DRS_FULL: inc = {8'h00, cond.q_full[0]};
      `IORP_EV_NCB_FULL: inc = {8'h00, cond.q_full[1]};
      `IORP_EV_NCS_FULL: inc = {8'h00, cond.q_full[2]};
      `IORP_EV_DRS_INS: inc = {8'h00, cond.q_ins[0]};
      `IORP_EV_NCB_INS: inc = {8'h00, cond.q_ins[1]};
      `IORP_EV_NCS_INS: inc = {8'h00, cond.q_ins[2]};
      `IORP_EV_DRS_OCC: inc = {1'b0, cond.drs_occ};
      `IORP_EV_NCB_OCC: inc = {1'b0, cond.ncb_occ};
      `IORP_EV_NCS_OCC: inc = {1'b0, cond.ncs_occ};
      // both rings stalled counts as two
      `IORP_EV_RING01_STALL: inc = {8'h00, cond.ring0_stall} +
        {8'h00, cond.ring1_stall};
      `IORP_EV_RING0_STALL: inc = {8'h00, cond.ring0_stall};
      `IORP_EV_RING1_STALL: inc = {8'h00, cond.ring1_stall};
      `IORP_EV_DATA_STALL: inc = {8'h00, cond.data_stall};
      `IORP_EV_SW_NCB: inc = {8'h00, cond.sw_ins[0]};
      `IORP_EV_SW_NCS: inc = {8'h00, cond.sw_ins[1]};
      `IORP_EV_SW_OCC: inc = {1'b0, cond.sw_occ};
      default: inc = 9'h000;
    endcase
  end

  // ========================================================
  // accumulator; software write beats counting in same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (clr) begin
      count_ff <= '0;
    end else if (wr_lo) begin
      count_ff <= {count_ff[WIDTH-1:32], wdata};
    end else if (wr_hi) begin
      count_ff <= {wdata[WIDTH-33:0], count_ff[31:0]};
    end else if (sel.en) begin
      count_ff <= count_ff + WIDTH'(inc);
    end
  end
endmodule
`default_nettype wire

// file: hdl/iorp_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "iorp_defs.svh"
module iorp_top #(
  parameter int CNT_WIDTH = 48
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iorp_pkg::iorp_cond_type cond
);
  // ==========================================================
  // apb slave state
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] ctl0_ff;     // counter 0 event select
  logic [31:0] ctl1_ff;     // counter 1 event select
  logic [3:0] filter_ff;    // source queue filter
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic wr_acc;             // write taken in access phase
  logic rd_acc;
  logic [CNT_WIDTH-1:0] cnt0;
  logic [CNT_WIDTH-1:0] cnt1;
  iorp_pkg::iorp_sel_type sel0;
  iorp_pkg::iorp_sel_type sel1;
  logic [1:0] clr;
  logic [1:0] wlo;
  logic [1:0] whi;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  // answer comes one cycle into the access phase: setup,
  // access with pready low, then pready high
  assign wr_acc = psel && penable && pwrite && pready_ff;
  assign rd_acc = psel && penable && !pwrite && !pready_ff;

  // ==========================================================
  // select decode, cast to struct
  assign sel0 = '{en: ctl0_ff[`IORP_EN_BIT],
    umask: ctl0_ff[`IORP_UM_LSB +: 8], code: ctl0_ff[`IORP_EV_LSB +: 8]};
  assign sel1 = '{en: ctl1_ff[`IORP_EN_BIT],
    umask: ctl1_ff[`IORP_UM_LSB +: 8], code: ctl1_ff[`IORP_EV_LSB +: 8]};

  // clear bit in a control write resets that counter
  assign clr[0] = wr_acc && paddr == `IORP_OFF_CTL0 &&
    pwdata[`IORP_CLR_BIT];
  assign clr[1] = wr_acc && paddr == `IORP_OFF_CTL1 &&
    pwdata[`IORP_CLR_BIT];
  assign wlo[0] = wr_acc && paddr == `IORP_OFF_CNT0_LO;
  assign whi[0] = wr_acc && paddr == `IORP_OFF_CNT0_HI;
  assign wlo[1] = wr_acc && paddr == `IORP_OFF_CNT1_LO;
  assign whi[1] = wr_acc && paddr == `IORP_OFF_CNT1_HI;

  // ==========================================================
  // pready: low in first access cycle, high in the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
    end else begin
      pready_ff <= 1'b0;
    end
  end

  // ==========================================================
  // control register writes; only two counters exist here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl0_ff <= `IORP_CTL_RESET;
      ctl1_ff <= `IORP_CTL_RESET;
      filter_ff <= 4'h0;
    end else if (wr_acc) begin
      case (paddr)
        `IORP_OFF_CTL0: begin
          ctl0_ff <= {8'h00, pwdata[23:0]} & 32'h0040_ffff;
        end
        `IORP_OFF_CTL1: begin
          ctl1_ff <= {8'h00, pwdata[23:0]} & 32'h0040_ffff;
        end
        `IORP_OFF_FILTER: begin
          filter_ff <= pwdata[3:0];
        end
        default: begin
          filter_ff <= filter_ff;
        end
      endcase
    end
  end

  // ==========================================================
  // read mux; unmapped addresses answer with pslverr
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    case (paddr)
      `IORP_OFF_CTL0: nxt_rdata = ctl0_ff;
      `IORP_OFF_CTL1: nxt_rdata = ctl1_ff;
      `IORP_OFF_CNT0_LO: nxt_rdata = cnt0[31:0];
      `IORP_OFF_CNT0_HI: nxt_rdata = {16'h0000, cnt0[CNT_WIDTH-1:32]};
      `IORP_OFF_CNT1_LO: nxt_rdata = cnt1[31:0];
      `IORP_OFF_CNT1_HI: nxt_rdata = {16'h0000, cnt1[CNT_WIDTH-1:32]};
      `IORP_OFF_FILTER: nxt_rdata = {28'h0000000, filter_ff};
      default: nxt_err = 1'b1;
    endcase
  end

  // read data and error latched as pready rises
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      prdata_ff <= rd_acc ? nxt_rdata : 32'h0000_0000;
      pslverr_ff <= nxt_err;
    end else begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  // ==========================================================
  // two identical counters, either can take any event
  iorp_counter #(.WIDTH(CNT_WIDTH)) u_cnt0 (
    .mclk(mclk),
    .rst(rst),
    .sel(sel0),
    .cond(cond),
    .filter_q(filter_ff),
    .clr(clr[0]),
    .wr_lo(wlo[0]),
    .wr_hi(whi[0]),
    .wdata(pwdata),
    .count(cnt0)
  );
  iorp_counter #(.WIDTH(CNT_WIDTH)) u_cnt1 (
    .mclk(mclk),
    .rst(rst),
    .sel(sel1),
    .cond(cond),
    .filter_q(filter_ff),
    .clr(clr[1]),
    .wr_lo(wlo[1]),
    .wr_hi(whi[1]),
    .wdata(pwdata),
    .count(cnt1)
  );
endmodule
`default_nettype wire

// file: sim/iorp_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// apb answer checks, ports of the top only
module iorp_top_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire iorp_pkg::iorp_cond_type cond
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // word offsets 0x000..0x018 are mapped, 0x01c and up are not
  wire logic mapped;
  assign mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 &&
    paddr[4:2] != 3'h7;
  // answer comes on the second access cycle, never the first
  ready_late_a:
    assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not on second access cycle");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready too long");
  ready_access_a:
    assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_with_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr alone");
  err_unmapped_a:
    assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  rdata_idle_a:
    assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read answer");
  rdata_unmap_a:
    assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  ctl_reserved_a:
    assert property (pready && !pwrite && paddr[11:3] == 9'h000 |->
      prdata[31:24] == 8'h00 && prdata[21:16] == 6'h00)
    else $error("reserved control bits read nonzero");
  cnt_hi_width_a:
    assert property (pready && !pwrite &&
      (paddr == 12'h00c || paddr == 12'h014) |-> prdata[31:16] == 16'h0)
    else $error("counter high word wider than 48 bits");
endmodule
bind iorp_top iorp_top_monitor mon (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond));
`default_nettype wire

// file: sim/io_ring_port_perf_event_counters_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module io_port_perf_event_counters_tb_top;
  // ========================================================
  // stimulus signals
  logic mclk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  iorp_pkg::iorp_cond_type cond;
  int n_fail = 0;
  int samples_checked = 0;
  // event codes under test, two unlisted ones count nothing
  logic [7:0] evs [22] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h13, 8'h14,
    8'h15, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h00, 8'h0b};
  iorp_top #(.CNT_WIDTH(48)) dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond));
  // ========================================================
  // clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ========================================================
  // helpers
  task automatic chk(input string nm, input logic [47:0] s, x);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one apb transfer; an idle cycle follows so no signal is set twice
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready wait", 1'b0, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // per-cycle increment of a counter for one event setting
  function automatic logic [47:0] inc(logic [7:0] ev, logic [7:0] um,
    iorp_pkg::iorp_cond_type c, logic [3:0] f);
    logic h;
    h = c.in_req & (um[1] & (c.in_kind[0] | c.in_retry) |
      (|(um[5:3] & c.in_kind[3:1]))) & (!um[6] | c.in_queue == f);
    case (ev)
      8'h02, 8'h03, 8'h04: inc = 48'(c.q_ins[ev - 8'h02]);
      8'h05, 8'h06, 8'h07: inc = 48'(c.q_full[ev - 8'h05]);
      8'h08: inc = 48'(c.drs_occ);
      8'h09: inc = 48'(c.ncb_occ);
      8'h0a: inc = 48'(c.ncs_occ);
      8'h0c: inc = 48'(c.sw_occ);
      8'h0d: inc = 48'(c.sw_ins[0]);
      8'h0e: inc = 48'(c.sw_ins[1]);
      8'h11: inc = 48'(h);
      8'h13: inc = 48'((|(um[3:0] & c.peer_kind)) &
        (|(um[7:4] & c.peer_where)));
      8'h14: inc = 48'(c.peer_req);
      8'h15: inc = 48'(c.peer_occ);
      8'h1a: inc = 48'(c.ring0_stall);
      8'h1b: inc = 48'(c.ring1_stall);
      8'h1c: inc = 48'(c.ring0_stall) + 48'(c.ring1_stall);
      8'h1d: inc = 48'(c.data_stall);
      default: inc = 48'h0;
    endcase
  endfunction
  // closing: counts, then verdict
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    results();
  end
  // ========================================================
  // main sequence
  initial begin
    logic [31:0] r, lo, hi;
    logic e;
    logic [7:0] ev, um;
    logic [3:0] f;
    logic [11:0] ca;
    logic [47:0] base;
    logic [95:0] rv;
    iorp_pkg::iorp_cond_type c;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cond = '0;
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    void'($urandom(32'hea27d192));
    // unmapped word is refused with zero data
    apb(1'b0, 12'h01c, 32'h0, r, e);
    chk("unmapped error", 48'(e), 48'h1);
    chk("unmapped data", 48'(r), 48'h0);
    // reserved and pulse bits of a control word read back zero
    apb(1'b1, 12'h004, 32'hffffffff, r, e);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("control readback", 48'(r), 48'h0040ffff);
    // a write to an unmapped word is refused the same way
    apb(1'b1, 12'h01c, 32'hffffffff, r, e);
    chk("unmapped write error", 48'(e), 48'h1);
    $display("test register map done");
    for (int i = 0; i < 44; i++) begin
      ev = evs[i % 22];
      um = (i % 3 == 0) ? 8'hff : 8'($urandom);
      f = 4'($urandom);
      ca = 12'((i / 22) * 4);
      // preload near the low-word wrap so the carry is exercised
      // random high half so a write to the upper word is proven too
      base = {16'($urandom), 32'hfffffff0};
      apb(1'b1, 12'h018, {28'h0, f}, r, e);
      apb(1'b1, ca * 2 + 12'h008, base[31:0], r, e);
      apb(1'b1, ca * 2 + 12'h00c, {16'h0, base[47:32]}, r, e);
      // odd passes clear on enable instead of keeping the preload
      apb(1'b1, ca, {8'h00, i[0], 1'b1, 6'h0, um, ev}, r, e);
      if (i[0]) base = 48'h0;
      repeat (30) begin
        rv = {$urandom, $urandom, $urandom};
        c = iorp_pkg::iorp_cond_type'(rv[69:0]);
        if ($urandom % 2) c.in_queue = f;
        cond <= c;
        base = base + inc(ev, um, c, f);
        @(posedge mclk);
      end
      cond <= '0;
      @(posedge mclk);
      // stop counting before reading both halves
      apb(1'b1, ca, {16'h0, um, ev}, r, e);
      apb(1'b0, ca * 2 + 12'h008, 32'h0, lo, e);
      apb(1'b0, ca * 2 + 12'h00c, 32'h0, hi, e);
      chk("count", {hi[15:0], lo}, base);
      chk("low", 48'(lo), 48'(base[31:0]));
      chk("high", 48'(hi[15:0]), 48'(base[47:32]));
      chk("sum", {hi[15:0], lo}, base);
      $display("test event %h counter %0d done", ev, i / 22);
    end
    results();
  end
endmodule
`default_nettype wire
